// ==== rtl/rdd_pkg.sv ====
// rdd_pkg: shared constants, register map and carrier types of the tag data decoder
// assumes a single 250 MHz system clock and an APB3 register port with 32-bit data

package rdd_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned ONESHOT_US = 10;
  // one-shot pulse is a least time, so round up to whole cycles
  localparam int unsigned ONESHOT_CYC = (ONESHOT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [11:0] ONESHOT_CYC_W = ONESHOT_CYC[11:0];

  // ==========================================================================
  // tag word layout
  localparam int unsigned WORD_BITS = 8;
  localparam int unsigned CODE_BITS = 3;
  localparam logic [2:0] PARITY_BIT = 3'h7;
  localparam int unsigned OUT_LINES = 8;
  // serial frame: start bit, three code bits, stop bit
  localparam logic [2:0] FRAME_LAST = 3'h4;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_DIV = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  // control fields
  localparam int unsigned CTRL_DEC_EN = 0;
  localparam int unsigned CTRL_OSC_EN = 1;
  localparam int unsigned CTRL_ONESHOT = 2;
  localparam int unsigned CTRL_ACT_LOW = 3;
  localparam logic [3:0] CTRL_RST = 4'h3;
  // output bit period in cycles
  localparam logic [15:0] DIV_RST = 16'h0100;
  // status fields
  localparam int unsigned STAT_CODE_LSB = 0;
  localparam int unsigned STAT_VALID = 3;
  localparam int unsigned STAT_BUSY = 4;
  localparam int unsigned STAT_ERR_LSB = 8;
  localparam int unsigned STAT_PER_LSB = 16;

  // ==========================================================================
  // carrier types
  typedef struct packed {
    logic activeLow;
    logic oneShot;
    logic oscEnable;
    logic decodeEnable;
  } rdd_ctrl_t;

  typedef struct packed {
    logic [2:0] code;
    logic parityOk;
  } rdd_word_t;

  typedef struct packed {
    logic syncClk;
    logic syncData;
    logic syncFrame;
    logic asyncLine;
  } rdd_ser_t;

endpackage

// ==== rtl/rdd_word_rx.sv ====
// rdd_word_rx: assembles demodulated tag bits into words and checks even parity
// assumes tag bit strobes are synchronous to sys_clk, one cycle wide

`timescale 1ns/1ps

module rdd_word_rx (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // control
  input wire logic decodeEnable,
  // demodulated tag stream
  input wire logic tagBit,
  input wire logic tagBitValid,
  input wire logic tagWordStart,
  // decoded word
  output rdd_pkg::rdd_word_t word,
  output logic [7:0] rawWord,
  output logic done,
  output logic [15:0] bitPeriod
);
  import rdd_pkg::*;

  logic [2:0] bitIdx, next_bitIdx;
  logic [7:0] shiftReg, next_shiftReg, next_rawWord;
  logic next_done;
  rdd_word_t next_word;
  logic [15:0] periodCnt, next_periodCnt, next_bitPeriod;

  // ==========================================================================
  // word assembly, bit 0 first; a start strobe realigns to bit 0
  always_comb begin
    logic [2:0] idx;
    logic [7:0] full;
    idx = tagWordStart ? 3'h0 : bitIdx;
    full = shiftReg;
    next_bitIdx = bitIdx;
    next_shiftReg = shiftReg;
    next_rawWord = rawWord;
    next_word = word;
    next_done = 1'b0;
    next_bitPeriod = bitPeriod;
    next_periodCnt = (periodCnt == 16'hffff) ? periodCnt : periodCnt + 16'h1;
    if (!decodeEnable) begin
      next_bitIdx = 3'h0;
    end else if (tagBitValid) begin
      full[idx] = tagBit;
      next_shiftReg = full;
      next_bitIdx = idx + 3'h1;
      // spacing of tag bits, used to keep the output rate below it
      next_bitPeriod = periodCnt;
      next_periodCnt = 16'h1;
      if (idx == PARITY_BIT) begin
        next_done = 1'b1;
        next_rawWord = full;
        next_word.code = full[CODE_BITS-1:0];
        next_word.parityOk = ~^full;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bitIdx <= 3'h0;
      shiftReg <= 8'h00;
      rawWord <= 8'h00;
      word <= '0;
      done <= 1'b0;
      bitPeriod <= 16'h0;
      periodCnt <= 16'h0;
    end else begin
      bitIdx <= next_bitIdx;
      shiftReg <= next_shiftReg;
      rawWord <= next_rawWord;
      word <= next_word;
      done <= next_done;
      bitPeriod <= next_bitPeriod;
      periodCnt <= next_periodCnt;
    end
  end

endmodule

// ==== rtl/rdd_ser_tx.sv ====
// rdd_ser_tx: re-sends a three-bit code as a synchronous and an asynchronous frame
// assumes period is at least two cycles; a start while busy is dropped

`timescale 1ns/1ps

module rdd_ser_tx (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // request
  input wire logic start,
  input wire logic [2:0] code,
  input wire logic [15:0] period,
  // serial lines
  output rdd_pkg::rdd_ser_t ser,
  output logic busy
);
  import rdd_pkg::*;

  logic next_busy;
  logic [2:0] bitNo, next_bitNo, dataReg, next_dataReg;
  logic [15:0] cnt, next_cnt;
  rdd_ser_t next_ser;

  // ==========================================================================
  // frame sequencer: bit 0 start, bits 1..3 code lsb first, bit 4 stop
  always_comb begin
    logic [1:0] sel;
    sel = 2'h0;
    next_busy = busy;
    next_bitNo = bitNo;
    next_cnt = cnt;
    next_dataReg = dataReg;
    if (!busy) begin
      if (start) begin
        next_busy = 1'b1;
        next_bitNo = 3'h0;
        next_cnt = 16'h0;
        next_dataReg = code;
      end
    end else if (cnt >= period - 16'h1) begin
      next_cnt = 16'h0;
      if (bitNo == FRAME_LAST) begin
        next_busy = 1'b0;
      end else begin
        next_bitNo = bitNo + 3'h1;
      end
    end else begin
      next_cnt = cnt + 16'h1;
    end
    // line levels follow the next state so they leave flops directly
    next_ser = '{syncClk: 1'b0, syncData: 1'b0, syncFrame: 1'b0, asyncLine: 1'b1};
    if (next_busy) begin
      sel = 2'(next_bitNo - 3'h1);
      if (next_bitNo == 3'h0) begin
        next_ser.asyncLine = 1'b0;
      end else if (next_bitNo != FRAME_LAST) begin
        next_ser.asyncLine = next_dataReg[sel];
        next_ser.syncData = next_dataReg[sel];
        next_ser.syncFrame = 1'b1;
        // clock rises mid-bit so the receiver samples settled data
        next_ser.syncClk = (next_cnt >= (period >> 1));
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      bitNo <= 3'h0;
      cnt <= 16'h0;
      dataReg <= 3'h0;
      ser <= '{syncClk: 1'b0, syncData: 1'b0, syncFrame: 1'b0, asyncLine: 1'b1};
    end else begin
      busy <= next_busy;
      bitNo <= next_bitNo;
      cnt <= next_cnt;
      dataReg <= next_dataReg;
      ser <= next_ser;
    end
  end

endmodule

// ==== rtl/rdd_reader_top.sv ====
// rdd_reader_top: digital back end of the tag reader; decodes tag words and presents
// them as synchronous serial, asynchronous serial or eight direct drive lines
// assumes tag strobes and mode pins are synchronous to sys_clk; APB3 register port
//
// The APB interface to the registers and the register addresses were left to the implementer.

`timescale 1ns/1ps

module rdd_reader_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // demodulated tag stream
  input wire logic tagBit,
  input wire logic tagBitValid,
  input wire logic tagWordStart,
  // mode pins
  input wire logic direct_output_select,
  input wire logic coil_drive_enable,
  // decoded outputs
  output logic [rdd_pkg::OUT_LINES-1:0] directOut,
  output rdd_pkg::rdd_ser_t serOut,
  // analog front-end controls
  output logic coilDriveOn,
  output logic oscRun
);
  import rdd_pkg::*;

  rdd_ctrl_t ctrl, next_ctrl;
  logic [15:0] divReg, next_divReg;
  logic [2:0] lastCode, next_lastCode;
  logic lastValid, next_lastValid;
  logic [7:0] errCnt, next_errCnt;
  logic [7:0] directRaw, next_directRaw, next_directOut;
  logic [11:0] shotCnt, next_shotCnt;
  logic txStart, next_txStart;
  logic next_pready, next_pslverr, next_coilDriveOn, next_oscRun;
  logic [31:0] next_prdata;
  logic [15:0] periodUsed;
  rdd_word_t rxWord;
  logic [7:0] rxRaw;
  logic rxDone, rxGood, txBusy, apbWrite;
  logic [15:0] tagPeriod;

  // ==========================================================================
  // submodules
  rdd_word_rx u_rx (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .decodeEnable(ctrl.decodeEnable),
    .tagBit(tagBit),
    .tagBitValid(tagBitValid),
    .tagWordStart(tagWordStart),
    .word(rxWord),
    .rawWord(rxRaw),
    .done(rxDone),
    .bitPeriod(tagPeriod)
  );

  rdd_ser_tx u_tx (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .start(txStart),
    .code(lastCode),
    .period(periodUsed),
    .ser(serOut),
    .busy(txBusy)
  );

  // ==========================================================================
  // output bit period: software divider, but never as fast as the tag stream
  always_comb begin
    if (divReg > tagPeriod) begin
      periodUsed = divReg;
    end else if (tagPeriod == 16'hffff) begin
      periodUsed = tagPeriod;
    end else begin
      periodUsed = tagPeriod + 16'h1;
    end
  end

  assign rxGood = rxDone & rxWord.parityOk;
  assign apbWrite = psel & penable & pready & pwrite;

  // ==========================================================================
  // decoded output path
  always_comb begin
    next_directRaw = directRaw;
    next_shotCnt = shotCnt;
    next_txStart = 1'b0;
    next_lastCode = lastCode;
    if (rxGood) begin
      next_lastCode = rxWord.code;
      if (direct_output_select) begin
        next_directRaw = 8'(8'h01 << rxWord.code);
        next_shotCnt = ONESHOT_CYC_W;
      end else begin
        next_txStart = 1'b1;
      end
    end else if (ctrl.oneShot && (|directRaw)) begin
      // one-shot: drop the line after the pulse time; level-hold keeps it
      if (shotCnt <= 12'h1) begin
        next_directRaw = 8'h00;
        next_shotCnt = 12'h0;
      end else begin
        next_shotCnt = shotCnt - 12'h1;
      end
    end
    // polarity is applied last so a change takes effect without a new word
    next_directOut = next_directRaw ^ {OUT_LINES{next_ctrl.activeLow}};
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      directRaw <= 8'h00;
      directOut <= 8'h00;
      shotCnt <= 12'h0;
      txStart <= 1'b0;
      lastCode <= 3'h0;
    end else begin
      directRaw <= next_directRaw;
      directOut <= next_directOut;
      shotCnt <= next_shotCnt;
      txStart <= next_txStart;
      lastCode <= next_lastCode;
    end
  end

  // ==========================================================================
  // register file and apb slave; zero wait states, answer one cycle after setup
  always_comb begin
    next_ctrl = ctrl;
    next_divReg = divReg;
    next_lastValid = lastValid;
    next_errCnt = errCnt;
    next_pready = psel & ~penable & ~pready;
    next_prdata = 32'h0;
    next_pslverr = 1'b0;
    // software clears first so a same-cycle hardware event still wins
    if (apbWrite && paddr == REG_CTRL) begin
      next_ctrl = rdd_ctrl_t'(pwdata[3:0]);
    end
    if (apbWrite && paddr == REG_DIV) begin
      next_divReg = (pwdata[15:0] < 16'h2) ? 16'h2 : pwdata[15:0];
    end
    if (apbWrite && paddr == REG_STATUS) begin
      if (pwdata[STAT_VALID]) begin
        next_lastValid = 1'b0;
      end
      if (pwdata[STAT_ERR_LSB]) begin
        next_errCnt = 8'h00;
      end
    end
    if (rxGood) begin
      next_lastValid = 1'b1;
    end
    // saturate on the value after a same-cycle clear so the count never wraps
    if (rxDone && !rxWord.parityOk && next_errCnt != 8'hff) begin
      next_errCnt = next_errCnt + 8'h1;
    end
    if (psel && !penable) begin
      unique case (paddr)
        REG_CTRL: next_prdata = {28'h0, ctrl};
        REG_DIV: next_prdata = {16'h0, divReg};
        REG_STATUS: next_prdata = {tagPeriod, errCnt, 3'h0, txBusy, lastValid, lastCode};
        default: next_pslverr = 1'b1;
      endcase
    end
    // driver and oscillator gated separately from the decoder
    next_oscRun = next_ctrl.oscEnable;
    next_coilDriveOn = next_ctrl.oscEnable & coil_drive_enable;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= rdd_ctrl_t'(CTRL_RST);
      divReg <= DIV_RST;
      lastValid <= 1'b0;
      errCnt <= 8'h00;
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
      oscRun <= 1'b0;
      coilDriveOn <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      divReg <= next_divReg;
      lastValid <= next_lastValid;
      errCnt <= next_errCnt;
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      oscRun <= next_oscRun;
      coilDriveOn <= next_coilDriveOn;
    end
  end

  // ==========================================================================
  // assertion helper: cycles the current direct line has been active in one-shot mode
  logic [11:0] runCnt;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      runCnt <= 12'h0;
    end else if (!(|next_directRaw)) begin
      runCnt <= 12'h0;
    end else if (rxGood && direct_output_select) begin
      runCnt <= 12'h1;
    end else if (!ctrl.oneShot) begin
      // a line left over from level-hold starts its one-shot time afresh
      runCnt <= 12'h0;
    end else if (runCnt != 12'hfff) begin
      runCnt <= runCnt + 12'h1;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_code_bits: assert property (
    rxDone |-> (rxWord.code == rxRaw[2:0]) && (rxWord.parityOk == ~^rxRaw))
    else $error("code or parity not taken from the right word bits");

  a_parity_gate: assert property (
    (rxDone && !rxWord.parityOk) |=> !txStart && (directRaw == $past(directRaw)
      || $past(ctrl.oneShot)))
    else $error("word with bad parity reached an output");

  a_direct_code: assert property (
    (rxGood && direct_output_select) |=> directRaw == 8'(8'h01 << $past(rxWord.code)))
    else $error("direct line does not match decoded code");

  a_direct_onehot: assert property ($onehot0(directOut ^ {OUT_LINES{ctrl.activeLow}}))
    else $error("more than one direct line active");

  a_serial_start: assert property (
    rxGood |=> (txStart == !$past(direct_output_select)))
    else $error("serial form started in the wrong mode");

  a_rate_slow: assert property (periodUsed > tagPeriod || tagPeriod == 16'hffff)
    else $error("serial bit period not longer than tag bit period");

  a_coil_off: assert property (!coil_drive_enable |=> !coilDriveOn && oscRun == ctrl.oscEnable)
    else $error("coil driver on while its enable is low");

  a_oneshot_len: assert property (ctrl.oneShot |-> runCnt <= ONESHOT_CYC_W)
    else $error("one-shot pulse longer than its time");

  a_hold_level: assert property (
    (!ctrl.oneShot && !(rxGood && direct_output_select)) |=> $stable(directRaw))
    else $error("level-hold output changed without a new word");

  a_decode_off: assert property (
    (!ctrl.decodeEnable && !tagBitValid) [*2] |=> !rxDone ##1 (oscRun == ctrl.oscEnable))
    else $error("decoder produced a word while disabled");

  // polarity is applied on the same edge as the control write, so the map holds every cycle
  a_polarity_map: assert property (
    directOut == (directRaw ^ {OUT_LINES{ctrl.activeLow}}))
    else $error("direct lines do not follow the selected polarity");

  a_serial_idle: assert property (
    !txBusy |-> serOut.asyncLine && !serOut.syncFrame && !serOut.syncClk)
    else $error("serial lines active outside a frame");

  a_direct_only: assert property (
    (rxGood && !direct_output_select && !ctrl.oneShot) |=> $stable(directRaw))
    else $error("serial-mode word changed the direct lines");

  // ==========================================================================
  // covers
  c_direct_word: cover property (rxGood && direct_output_select ##1 |directRaw);
  c_serial_frame: cover property (txStart ##1 txBusy);
  c_parity_fail: cover property (rxDone && !rxWord.parityOk);
  c_low_active: cover property (ctrl.activeLow && |directRaw);
  c_oneshot_end: cover property (ctrl.oneShot && runCnt == ONESHOT_CYC_W ##1 directRaw == 8'h00);

endmodule

// ==== dv/rdd_host_model.sv ====
// rdd_host_model: behavioural host that listens to the serial output forms
// assumes the bench tells it the output bit period in cycles

`timescale 1ns/1ps

module rdd_host_model #(
  parameter int PERIOD = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // serial lines from the reader
  input wire rdd_pkg::rdd_ser_t serOut,
  // what the host understood
  output logic [2:0] asyncCode,
  output logic [2:0] syncCode,
  output int lowRun,
  output int startLen
);
  import rdd_pkg::*;
  // ==========================================================================
  // asynchronous receiver: samples each bit in its middle
  initial begin
    asyncCode = 3'h0;
    forever begin
      @(negedge serOut.asyncLine);
      repeat (PERIOD / 2) @(posedge sys_clk);
      for (int i = 0; i < 3; i++) begin
        repeat (PERIOD) @(posedge sys_clk);
        asyncCode[i] = serOut.asyncLine;
      end
      // skip the stop bit so data lows do not retrigger
      repeat (PERIOD) @(posedge sys_clk);
    end
  end
  // ==========================================================================
  // start bit length, only exact when code bit 0 is one
  always @(posedge sys_clk) begin
    if (!resetn) begin
      lowRun <= 0;
      startLen <= 0;
    end else if (!serOut.asyncLine) begin
      lowRun <= lowRun + 1;
    end else if (lowRun != 0) begin
      startLen <= lowRun;
      lowRun <= 0;
    end
  end
  // ==========================================================================
  // synchronous receiver: lsb first on the rising clock inside the frame
  initial syncCode = 3'h0;
  always @(posedge serOut.syncClk) begin
    if (serOut.syncFrame) begin
      syncCode <= {serOut.syncData, syncCode[2:1]};
    end
  end
endmodule

// ==== dv/rfid_reader_data_decoder_tb_top.sv ====
// rfid_reader_data_decoder_tb_top: directed bench for the tag reader back end
// assumes one 250 MHz clock; host model listens on the serial forms

`timescale 1ns/1ps

module rfid_reader_data_decoder_tb_top;
  import rdd_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic tagBit = 1'b0;
  logic tagBitValid = 1'b0;
  logic tagWordStart = 1'b0;
  logic direct_output_select = 1'b1;
  logic coil_drive_enable = 1'b1;
  logic [OUT_LINES-1:0] directOut;
  rdd_ser_t serOut;
  logic coilDriveOn;
  logic oscRun;
  logic [2:0] asyncCode;
  logic [2:0] syncCode;
  int lowRun;
  int startLen;
  int nFail = 0;
  int testsRun = 0;
  logic [31:0] rd;

  always #2 sys_clk = ~sys_clk;

  rdd_reader_top DUT (.sys_clk(sys_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .tagBit(tagBit), .tagBitValid(tagBitValid), .tagWordStart(tagWordStart),
    .direct_output_select(direct_output_select), .coil_drive_enable(coil_drive_enable),
    .directOut(directOut), .serOut(serOut), .coilDriveOn(coilDriveOn), .oscRun(oscRun));

  rdd_host_model #(.PERIOD(8)) host (.sys_clk(sys_clk), .resetn(resetn), .serOut(serOut),
    .asyncCode(asyncCode), .syncCode(syncCode), .lowRun(lowRun), .startLen(startLen));

  // ==========================================================================
  // shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic giveVerdict();
    if (nFail == 0 && testsRun > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // waits n edges, then lands on the settled half of the cycle
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // one apb transfer; the answer is taken at the rising edge that samples pready high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask

  // one tag word, bits two cycles apart, parity made even unless bad is set
  task automatic send(input logic [2:0] code, input logic bad);
    logic [7:0] w;
    w[6:0] = {4'h5, code};
    w[7] = (^w[6:0]) ^ bad;
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      tagBit <= w[i];
      tagBitValid <= 1'b1;
      tagWordStart <= (i == 0);
      @(posedge sys_clk);
      tagBitValid <= 1'b0;
      tagWordStart <= 1'b0;
    end
    settle(3);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset_regs();
    logic e;
    apb(REG_CTRL, 1'b0, 32'h0, rd, e);
    check(rd, 32'h3);
    apb(REG_DIV, 1'b0, 32'h0, rd, e);
    check(rd, 32'h100);
    apb(12'h00c, 1'b0, 32'h0, rd, e);
    check(rd, 32'h0);
    check({31'h0, e}, 32'h1);
    check({oscRun, coilDriveOn}, 2'h3);
  endtask

  task automatic t_direct_all();
    for (int c = 0; c < 8; c++) begin
      send(c[2:0], 1'b0);
      check(directOut, 8'h01 << c);
    end
    settle(100);
    check(directOut, 8'h80);
  endtask

  task automatic t_bad_parity();
    logic e;
    wr(REG_STATUS, 32'h108);
    send(3'h3, 1'b0);
    send(3'h6, 1'b1);
    check(directOut, 8'h08);
    apb(REG_STATUS, 1'b0, 32'h0, rd, e);
    check({rd[15:8], rd[3:0]}, {8'h01, 4'hb});
  endtask

  task automatic t_polarity();
    wr(REG_CTRL, 32'hb);
    settle(2);
    check(directOut, 8'hf7);
    send(3'h1, 1'b0);
    check(directOut, 8'hfd);
    wr(REG_CTRL, 32'h3);
  endtask

  task automatic t_one_shot();
    wr(REG_CTRL, 32'h7);
    send(3'h2, 1'b0);
    check(directOut, 8'h04);
    settle(2400);
    check(directOut, 8'h04);
    settle(200);
    check(directOut, 8'h00);
    wr(REG_CTRL, 32'h3);
  endtask

  task automatic t_enables();
    @(posedge sys_clk);
    coil_drive_enable <= 1'b0;
    send(3'h4, 1'b0);
    check({oscRun, coilDriveOn, directOut}, {2'h2, 8'h10});
    @(posedge sys_clk);
    coil_drive_enable <= 1'b1;
    wr(REG_CTRL, 32'h1);
    send(3'h6, 1'b0);
    check({oscRun, coilDriveOn, directOut}, {2'h0, 8'h40});
    wr(REG_CTRL, 32'h2);
    send(3'h0, 1'b0);
    check({oscRun, coilDriveOn, directOut}, {2'h3, 8'h40});
    wr(REG_CTRL, 32'h3);
  endtask

  task automatic t_serial();
    wr(REG_DIV, 32'h8);
    @(posedge sys_clk);
    direct_output_select <= 1'b0;
    send(3'h5, 1'b0);
    settle(60);
    check({asyncCode, syncCode}, {3'h5, 3'h5});
    check(startLen, 8);
    check(serOut, 4'h1);
    @(posedge sys_clk);
    direct_output_select <= 1'b1;
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset_regs();
    t_direct_all();
    t_bad_parity();
    t_polarity();
    t_one_shot();
    t_enables();
    t_serial();
    giveVerdict();
  end

  // the run needs about 3100 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    nFail++;
    giveVerdict();
  end
endmodule
